/* File: verilog/ddcp_top.sv */
// digital path configuration registers with an APB slave port
//
// Function
// - 20-bit frame clock pattern, resets to FFC00
// - bypass picks pattern from output resolution
// - select 00 routes A only, 01 both
// - path enable clear bypasses feature block
// - one bit enables both decimators
// - select codes act only with select enable
// - ratio 000 none, 001-101 by 2..32
// - real bit skips mixing, lowpass only
// - phase bit inverts oscillator phase
// - reload bit toggle resets phase, loads
// - gain codes give 0, 3, 6 dB
`timescale 1ns/1ps
`default_nettype none
`include "ddcp_consts.svh"

module ddcp_top
  import ddcp_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [1:0]        OUTPUT_RESOLUTION,
  output logic      [19:0]       FRAME_CLOCK_PATTERN,
  output logic                   DIGITAL_PATH_ON,
  output logic                   DECIMATION_ACTIVE,
  output logic      [2:0]        DECIMATION_LOG2,
  output logic                   ROUTE_A_TO_B,
  output logic                   MIX_ENABLE,
  output logic                   PHASE_INVERT,
  output logic                   RELOAD_A,
  output logic                   RELOAD_B,
  output logic      [1:0]        GAIN_A,
  output logic      [1:0]        GAIN_B,
  output logic                   QUARTER_RATE_MIX_A,
  output logic                   QUARTER_RATE_MIX_B
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  ddcp_cfg_type cfg_q;
  ddcp_cfg_type cfg_d;
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  prdata_q;

  wire logic hit_pattern = PADDR == {`DDCP_IDX_PATTERN, 2'b00};
  wire logic hit_path    = PADDR == {`DDCP_IDX_PATH, 2'b00};
  wire logic hit_decim   = PADDR == {`DDCP_IDX_DECIM, 2'b00};
  wire logic hit_mixer   = PADDR == {`DDCP_IDX_MIXER, 2'b00};
  wire logic hit_any     = hit_pattern | hit_path | hit_decim | hit_mixer;

  // access phase waits one cycle, then pready is high for one cycle
  wire logic acc_wait = PSEL & PENABLE & ~pready_q;
  wire logic acc_done = PSEL & PENABLE & pready_q;
  wire logic wr_ok    = acc_done & PWRITE & hit_any;

  wire logic [7:0] path_byte = {3'h0, cfg_q.input_sel, cfg_q.path_en,
                                cfg_q.dec_en, 1'b0};
  wire logic [7:0] decim_byte = {cfg_q.sel_en, cfg_q.ratio,
                                 cfg_q.real_out, 2'h0, cfg_q.phase_inv};
  wire logic [7:0] mixer_byte = {cfg_q.gain_a, cfg_q.reload_a,
                                 cfg_q.qmix_a, cfg_q.gain_b,
                                 cfg_q.reload_b, cfg_q.qmix_b};

  wire logic [31:0] rd_mux =
    hit_pattern ? {12'h000, cfg_q.pattern} :
    hit_path    ? {24'h000000, path_byte} :
    hit_decim   ? {24'h000000, decim_byte} :
    hit_mixer   ? {24'h000000, mixer_byte} : 32'h00000000;

  // ****************************************************************
  // register write
  // ****************************************************************
  wire logic [19:0] pat_mask = {{4{PSTRB[2]}}, {8{PSTRB[1]}},
                                {8{PSTRB[0]}}};
  wire logic        wr_lane0 = wr_ok & PSTRB[0];
  wire logic [19:0] pat_new  = (cfg_q.pattern & ~pat_mask) |
                               (PWDATA[19:0] & pat_mask);

  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_ok && hit_pattern)
    begin
      cfg_d.pattern = pat_new;
    end
    else if (wr_lane0 && hit_path)
    begin
      cfg_d.input_sel = PWDATA[`DDCP_SEL_HI:`DDCP_SEL_LO];
      cfg_d.path_en   = PWDATA[`DDCP_PATH_EN_BIT];
      cfg_d.dec_en    = PWDATA[`DDCP_DEC_EN_BIT];
    end
    else if (wr_lane0 && hit_decim)
    begin
      cfg_d.sel_en    = PWDATA[`DDCP_SEL_EN_BIT];
      cfg_d.ratio     = PWDATA[`DDCP_RATIO_HI:`DDCP_RATIO_LO];
      cfg_d.real_out  = PWDATA[`DDCP_REAL_BIT];
      cfg_d.phase_inv = PWDATA[`DDCP_PHASE_BIT];
    end
    else if (wr_lane0 && hit_mixer)
    begin
      cfg_d.gain_a    = PWDATA[`DDCP_GAIN_A_HI:`DDCP_GAIN_A_LO];
      cfg_d.reload_a  = PWDATA[`DDCP_RELOAD_A_BIT];
      cfg_d.qmix_a    = PWDATA[`DDCP_QMIX_A_BIT];
      cfg_d.gain_b    = PWDATA[`DDCP_GAIN_B_HI:`DDCP_GAIN_B_LO];
      cfg_d.reload_b  = PWDATA[`DDCP_RELOAD_B_BIT];
      cfg_d.qmix_b    = PWDATA[`DDCP_QMIX_B_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cfg_q         <= '0;
      cfg_q.pattern <= `DDCP_RST_PATTERN;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= acc_wait;
      pslverr_q <= acc_wait & ~hit_any;
      prdata_q  <= (acc_wait & ~PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************************************
  // derived controls
  // ****************************************************************
  wire logic ratio_ok   = cfg_q.ratio <= 3'h5;
  wire logic dec_active = cfg_q.path_en & cfg_q.dec_en &
                          (cfg_q.ratio != 3'h0) & ratio_ok;

  // automatic pattern when decimation is bypassed
  ddcp_res_type res;
  assign res = ddcp_res_type'(OUTPUT_RESOLUTION);
  wire logic [19:0] auto_pat =
    (res == DDCP_RES_14) ? `DDCP_PAT_14B :
    (res == DDCP_RES_16) ? `DDCP_PAT_16B :
    (res == DDCP_RES_18) ? `DDCP_PAT_18B : `DDCP_PAT_20B;
  wire logic [19:0] pat_d = dec_active ? cfg_q.pattern : auto_pat;

  // code 01 feeds channel A to both decimators
  // codes ignored while select enable is clear
  wire logic route_d = cfg_q.sel_en &
                       (cfg_q.input_sel == DDCP_SEL_A_BOTH);
  // real mode runs lowpass only, no mixing
  wire logic mix_d   = dec_active & ~cfg_q.real_out;
  // unused gain code adds no gain
  wire logic [1:0] gain_a_d = (cfg_q.gain_a == 2'h3) ? 2'h0 : cfg_q.gain_a;
  wire logic [1:0] gain_b_d = (cfg_q.gain_b == 2'h3) ? 2'h0 : cfg_q.gain_b;

  logic [19:0] pat_q;
  logic        dec_active_q;
  logic [2:0]  log2_q;
  logic        route_q;
  logic        mix_q;
  logic        reload_a_q;
  logic        reload_b_q;
  logic [1:0]  gain_a_q;
  logic [1:0]  gain_b_q;
  logic        prev_a_q;
  logic        prev_b_q;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pat_q        <= `DDCP_RST_PATTERN;
      dec_active_q <= 1'b0;
      log2_q       <= 3'h0;
      route_q      <= 1'b0;
      mix_q        <= 1'b0;
      gain_a_q     <= 2'h0;
      gain_b_q     <= 2'h0;
    end
    else
    begin
      pat_q        <= pat_d;
      // decimation gated by path, decimator enable and ratio
      dec_active_q <= dec_active;
      log2_q       <= dec_active ? cfg_q.ratio : 3'h0;
      route_q      <= route_d;
      mix_q        <= mix_d;
      gain_a_q     <= gain_a_d;
      gain_b_q     <= gain_b_d;
    end
  end

  // a toggle of a reload bit gives a one-cycle pulse
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      prev_a_q   <= 1'b0;
      prev_b_q   <= 1'b0;
      reload_a_q <= 1'b0;
      reload_b_q <= 1'b0;
    end
    else
    begin
      prev_a_q   <= cfg_q.reload_a;
      prev_b_q   <= cfg_q.reload_b;
      reload_a_q <= cfg_q.reload_a ^ prev_a_q;
      reload_b_q <= cfg_q.reload_b ^ prev_b_q;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA              = prdata_q;
  assign PREADY              = pready_q;
  assign PSLVERR             = pslverr_q;
  assign FRAME_CLOCK_PATTERN = pat_q;
  // feature block in the path only when enabled
  assign DIGITAL_PATH_ON     = cfg_q.path_en;
  assign DECIMATION_ACTIVE   = dec_active_q;
  assign DECIMATION_LOG2     = log2_q;
  assign ROUTE_A_TO_B        = route_q;
  assign MIX_ENABLE          = mix_q;
  assign PHASE_INVERT        = cfg_q.phase_inv;
  assign RELOAD_A            = reload_a_q;
  assign RELOAD_B            = reload_b_q;
  assign GAIN_A              = gain_a_q;
  assign GAIN_B              = gain_b_q;
  assign QUARTER_RATE_MIX_A  = cfg_q.qmix_a;
  assign QUARTER_RATE_MIX_B  = cfg_q.qmix_b;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking ast_clk @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  AST_PATTERN_WRITE:
    assert property (wr_ok && hit_pattern && PSTRB == 4'hF |=>
                     cfg_q.pattern == $past(PWDATA[19:0]))
    else $error("pattern write not stored");

  AST_AUTO_PATTERN:
    assert property (!dec_active && res == DDCP_RES_16 |=>
                     FRAME_CLOCK_PATTERN == 20'hFF000)
    else $error("bypass pattern not adapted");

  AST_ROUTE_BOTH:
    assert property (cfg_q.sel_en && cfg_q.input_sel == 2'h1 |=>
                     ROUTE_A_TO_B)
    else $error("select 01 did not route to both");

  AST_SELECT_GATED:
    assert property (!cfg_q.sel_en |=> !ROUTE_A_TO_B)
    else $error("route active without select enable");

  AST_PATH_BYPASS:
    assert property (!DIGITAL_PATH_ON |=> !DECIMATION_ACTIVE && !MIX_ENABLE)
    else $error("features active while bypassed");

  AST_DEC_OFF:
    assert property (!cfg_q.dec_en |=> DECIMATION_LOG2 == 3'h0)
    else $error("decimation with decimator disabled");

  AST_RATIO:
    assert property (cfg_q.path_en && cfg_q.dec_en && cfg_q.ratio == 3'h5
                     |=> DECIMATION_LOG2 == 3'h5 && DECIMATION_ACTIVE)
    else $error("ratio 101 not applied");

  AST_REAL_NO_MIX:
    assert property (cfg_q.real_out |=> !MIX_ENABLE)
    else $error("mixing while in real mode");

  AST_PHASE_WRITE:
    assert property (wr_lane0 && hit_decim |=>
                     PHASE_INVERT == $past(PWDATA[0]))
    else $error("phase invert not taken");

  AST_RELOAD_PULSE:
    assert property ($changed(cfg_q.reload_a) |-> ##1 RELOAD_A ##1 !RELOAD_A)
    else $error("reload pulse wrong");

  AST_PATH_WRITE:
    assert property (wr_lane0 && hit_path |=>
                     DIGITAL_PATH_ON == $past(PWDATA[2]))
    else $error("path enable not taken");

  AST_QMIX_WRITE:
    assert property (wr_lane0 && hit_mixer |=>
                     QUARTER_RATE_MIX_A == $past(PWDATA[4]))
    else $error("quarter rate mix not taken");

  AST_GAIN_UNUSED:
    assert property (cfg_q.gain_a == 2'h3 |=> GAIN_A == 2'h0)
    else $error("unused gain code applied");

  AST_READY_ONE:
    assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not a single pulse");

  COV_WRITE_PATTERN:
    cover property (wr_ok && hit_pattern);
  COV_DECIM_COMPLEX:
    cover property (DECIMATION_ACTIVE && MIX_ENABLE);
  COV_ROUTE:
    cover property (ROUTE_A_TO_B);
  COV_UNMAPPED:
    cover property (PSLVERR);

endmodule : ddcp_top

`default_nettype wire

/* File: verilog/ddcp_consts.svh */
// register indices, field positions and reset values of the path config
`ifndef DDCP_CONSTS_SVH
`define DDCP_CONSTS_SVH

// register indices; byte address is four times the index
`define DDCP_IDX_PATTERN   6'h20
`define DDCP_IDX_PATH      6'h24
`define DDCP_IDX_DECIM     6'h25
`define DDCP_IDX_MIXER     6'h26

// reset values
`define DDCP_RST_PATTERN   20'hFFC00
`define DDCP_RST_BYTE      8'h00

// automatic frame clock patterns per output resolution
`define DDCP_PAT_14B       20'hFE000
`define DDCP_PAT_16B       20'hFF000
`define DDCP_PAT_18B       20'hFF800
`define DDCP_PAT_20B       20'hFFC00

// digital_path_control fields
`define DDCP_SEL_HI        4
`define DDCP_SEL_LO        3
`define DDCP_PATH_EN_BIT   2
`define DDCP_DEC_EN_BIT    1

// decimation_config fields
`define DDCP_SEL_EN_BIT    7
`define DDCP_RATIO_HI      6
`define DDCP_RATIO_LO      4
`define DDCP_REAL_BIT      3
`define DDCP_PHASE_BIT     0

// mixer_control fields
`define DDCP_GAIN_A_HI     7
`define DDCP_GAIN_A_LO     6
`define DDCP_RELOAD_A_BIT  5
`define DDCP_QMIX_A_BIT    4
`define DDCP_GAIN_B_HI     3
`define DDCP_GAIN_B_LO     2
`define DDCP_RELOAD_B_BIT  1
`define DDCP_QMIX_B_BIT    0

`endif

/* File: verilog/ddcp_pkg.sv */
// types of the digital path configuration block
package ddcp_pkg;

  typedef enum logic [1:0] {
    DDCP_RES_18 = 2'h0,
    DDCP_RES_16 = 2'h1,
    DDCP_RES_14 = 2'h2,
    DDCP_RES_20 = 2'h3
  } ddcp_res_type;

  typedef enum logic [1:0] {
    DDCP_SEL_A_ONLY = 2'h0,
    DDCP_SEL_A_BOTH = 2'h1
  } ddcp_sel_type;

  typedef struct packed {
    logic [19:0] pattern;
    logic [1:0]  input_sel;
    logic        path_en;
    logic        dec_en;
    logic        sel_en;
    logic [2:0]  ratio;
    logic        real_out;
    logic        phase_inv;
    logic [1:0]  gain_a;
    logic        reload_a;
    logic        qmix_a;
    logic [1:0]  gain_b;
    logic        reload_b;
    logic        qmix_b;
  } ddcp_cfg_type;

endpackage : ddcp_pkg

/* File: verif/ddcp_top_tb_top.sv */
// self-checking bench of the digital path configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "ddcp_consts.svh"

module ddcp_top_tb_top
  import ddcp_pkg::*;
;
  localparam logic [7:0] A_PAT = {`DDCP_IDX_PATTERN, 2'h0};
  localparam logic [7:0] A_PTH = {`DDCP_IDX_PATH, 2'h0};
  localparam logic [7:0] A_DEC = {`DDCP_IDX_DECIM, 2'h0};
  localparam logic [7:0] A_MIX = {`DDCP_IDX_MIXER, 2'h0};
  localparam logic [31:0] USR = 32'h00012345;

  logic        core_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  out_res;
  logic [19:0] fc_pat;
  logic        path_on;
  logic        dec_act;
  logic [2:0]  dec_log2;
  logic        route_ab;
  logic        mix_en;
  logic        ph_inv;
  logic        rld_a;
  logic        rld_b;
  logic [1:0]  gain_a;
  logic [1:0]  gain_b;
  logic        qmix_a;
  logic        qmix_b;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          samples_checked;
  int          cycles;

  ddcp_top ddcp_top_i (
    .CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OUTPUT_RESOLUTION(out_res), .FRAME_CLOCK_PATTERN(fc_pat),
    .DIGITAL_PATH_ON(path_on), .DECIMATION_ACTIVE(dec_act),
    .DECIMATION_LOG2(dec_log2), .ROUTE_A_TO_B(route_ab),
    .MIX_ENABLE(mix_en), .PHASE_INVERT(ph_inv), .RELOAD_A(rld_a),
    .RELOAD_B(rld_b), .GAIN_A(gain_a), .GAIN_B(gain_b),
    .QUARTER_RATE_MIX_A(qmix_a), .QUARTER_RATE_MIX_B(qmix_b)
  );

  // ****************************************
  // common tasks
  // ****************************************
  task automatic final_report();
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask : settle

  function automatic logic [19:0] auto_pat(input logic [1:0] r);
    case (r)
      2'h0:    return `DDCP_PAT_18B;
      2'h1:    return `DDCP_PAT_16B;
      2'h2:    return `DDCP_PAT_14B;
      default: return `DDCP_PAT_20B;
    endcase
  endfunction : auto_pat

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rdchk(A_PAT, 32'h000FFC00);
    chk(er, 1'b0);
    rdchk(A_PTH, 32'h0);
    rdchk(A_DEC, 32'h0);
    rdchk(A_MIX, 32'h0);
    chk(fc_pat, `DDCP_PAT_18B);
    chk({dec_act, path_on, mix_en, route_ab}, 4'h0);
  endtask : t_reset

  task automatic t_auto();
    apb(1'b1, A_PAT, USR);
    rdchk(A_PAT, USR);
    for (int r = 0; r < 4; r++)
    begin
      out_res <= r[1:0];
      settle();
      chk(fc_pat, auto_pat(r[1:0]));
    end
  endtask : t_auto

  task automatic t_ratio();
    logic act;
    apb(1'b1, A_PAT, {12'h000, `DDCP_PAT_14B});
    apb(1'b1, A_PTH, 32'h06);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, A_DEC, {25'h0, k[2:0], 4'h8});
      settle();
      act = (k >= 1 && k <= 5);
      chk(dec_act, act);
      chk(dec_log2, act ? k[2:0] : 3'h0);
      chk(fc_pat, act ? `DDCP_PAT_14B : auto_pat(out_res));
      chk(mix_en, 1'b0);
    end
  endtask : t_ratio

  task automatic t_modes();
    apb(1'b1, A_PAT, 32'h000FFFFF);
    apb(1'b1, A_DEC, 32'h31);
    settle();
    chk({mix_en, ph_inv, path_on}, 3'h7);
    chk(fc_pat, 20'hFFFFF);
    apb(1'b1, A_PTH, 32'h02);
    settle();
    chk({path_on, dec_act, mix_en}, 3'h0);
    apb(1'b1, A_PTH, 32'h04);
    settle();
    chk({path_on, dec_act}, 2'h2);
    apb(1'b1, A_DEC, 32'h30);
    settle();
    chk(ph_inv, 1'b0);
  endtask : t_modes

  task automatic t_select();
    logic [3:0] tbl [3] = '{4'b0_01_0, 4'b1_01_1, 4'b1_00_0};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, A_PTH, {27'h0, tbl[i][2:1], 3'h6});
      apb(1'b1, A_DEC, {24'h0, tbl[i][3], 7'h10});
      settle();
      chk(route_ab, tbl[i][0]);
    end
  endtask : t_select

  task automatic pulses(input int ea, input int eb);
    int ca;
    int cb;
    ca = 0;
    cb = 0;
    repeat (6)
    begin
      @(posedge core_clk);
      ca += (rld_a === 1'b1);
      cb += (rld_b === 1'b1);
    end
    chk(ca, ea);
    chk(cb, eb);
  endtask : pulses

  task automatic t_mixer();
    logic [1:0] g;
    for (int i = 0; i < 4; i++)
    begin
      g = i[1:0];
      apb(1'b1, A_MIX, {24'h0, g, 2'h1, g, 2'h0});
      settle();
      chk({gain_a, gain_b}, (g == 2'h3) ? 4'h0 : {g, g});
      chk({qmix_a, qmix_b}, 2'h2);
    end
    apb(1'b1, A_MIX, 32'h20);
    pulses(1, 0);
    rdchk(A_MIX, 32'h20);
    apb(1'b1, A_MIX, 32'h02);
    pulses(1, 1);
  endtask : t_mixer

  task automatic t_err();
    apb(1'b1, 8'hFC, 32'hFF);
    chk(er, 1'b1);
    rdchk(8'hFC, 32'h0);
    chk(er, 1'b1);
    pstrb <= 4'h0;
    apb(1'b1, A_MIX, 32'h55);
    pstrb <= 4'hF;
    rdchk(A_MIX, 32'h02);
  endtask : t_err

  task automatic t_rerst();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({rld_b, gain_a, fc_pat}, {3'h0, `DDCP_RST_PATTERN});
    rst_b <= 1'b1;
    rdchk(A_PAT, {12'h000, `DDCP_RST_PATTERN});
    rdchk(A_MIX, 32'h0);
  endtask : t_rerst

  // ****************************************
  // clock, timeout and main sequence
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    out_res = 2'h0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_auto();
    t_ratio();
    t_modes();
    t_select();
    t_mixer();
    t_err();
    t_rerst();
    final_report();
  end
endmodule : ddcp_top_tb_top

`default_nettype wire
